// *** hw/psc_consts.vh ***
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
// ascii characters
`define PSC_CH_COLON 8'h3a
`define PSC_CH_CR 8'h0d
`define PSC_CH_LF 8'h0a
`define PSC_CH_SP 8'h20
`define PSC_CH_COMMA 8'h2c
`define PSC_CH_TAB 8'h09
`define PSC_CH_EQ 8'h3d
`define PSC_CH_ZERO 8'h30
`define PSC_CH_TWO 8'h32
`define PSC_CH_MINUS 8'h2d
`define PSC_CH_A 8'h41
`define PSC_CH_N 8'h4e
`define PSC_CH_X 8'h58
`define PSC_CH_E 8'h45
`define PSC_CH_LT 8'h3c
`define PSC_CH_GT 8'h3e
`define PSC_CH_LP 8'h28
`define PSC_CH_RP 8'h29
`define PSC_CH_P 8'h50
`define PSC_CH_S 8'h53
`define PSC_CH_I 8'h49
`define PSC_CH_F 8'h46
`define PSC_CH_M 8'h4d
`define PSC_CH_W 8'h57
`define PSC_CH_V 8'h56
`define PSC_CH_DOT 8'h2e
// reply line kinds
`define PSC_LN_NONE 4'h0
`define PSC_LN_ACK 4'h1
`define PSC_LN_NAK 4'h2
`define PSC_LN_POS 4'h3
`define PSC_LN_STAT 4'h4
`define PSC_LN_SI5 4'h5
`define PSC_LN_SIX 4'h6
`define PSC_LN_BANNER 4'h7
`define PSC_LN_FATAL 4'h8
// reply line lengths without cr lf
`define PSC_LEN_ACK 6'h01
`define PSC_LEN_POS 6'h0b
`define PSC_LEN_STAT 6'h06
`define PSC_LEN_SI 6'h20
`define PSC_LEN_BANNER 6'h0d
`define PSC_LEN_FATAL 6'h16
// field widths in characters and info line numbers
`define PSC_POS_DIGITS 4'h8
`define PSC_STAT_DIGITS 4'h3
`define PSC_SI_LAST 5'h10
`define PSC_SI_POS_LINE 5'h05
// command buffer
`define PSC_CMD_MAX 4'hf
// version digits for the banner, arbitrary values
`define PSC_VER_HI 8'h01
`define PSC_VER_LO 8'h02
`endif

// *** hw/psc_dec_digit.v ***
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.vh"
// ----------------------------------------
// right aligned decimal field character
// ----------------------------------------
// picks the ascii character at column col of a right aligned,
// blank padded field of width chars; leading zeros become blanks
module psc_dec_digit (
	input wire [31:0] value,
	input wire [3:0] width,
	input wire [3:0] col,
	input wire blank_all,
	output reg [7:0] ch
);
	reg [31:0] mag;
	reg [31:0] div;
	reg [3:0] place;
	reg [3:0] ndig;
	reg [31:0] t;
	reg [31:0] dval;
	integer i;
	// combinational digit extraction, one field column at a time
	always @* begin
		mag = value[31] ? (~value + 32'h00000001) : value;
		place = width - col - 4'h1;
		div = 32'h00000001;
		for (i = 0; i < 10; i = i + 1) begin
			if (i < place)
				div = div * 32'h0000000a;
		end
		ndig = 4'h1;
		t = mag;
		for (i = 0; i < 10; i = i + 1) begin
			if (t >= 32'h0000000a) begin
				t = t / 32'h0000000a;
				ndig = ndig + 4'h1;
			end
		end
		// digit value is below ten, so the low byte holds all of it
		dval = (mag / div) % 32'h0000000a;
		ch = `PSC_CH_SP;
		if (blank_all)
			ch = `PSC_CH_SP;
		else if (place < ndig)
			ch = `PSC_CH_ZERO + dval[7:0];
		else if (value[31] && place == ndig)
			ch = `PSC_CH_MINUS;
	end
endmodule
`default_nettype wire

// *** hw/psc_polled_cmd.v ***
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.vh"
module psc_polled_cmd (
	input wire clock,
	input wire rst_n,
	input wire [7:0] rx_data,
	input wire rx_valid,
	output reg [7:0] tx_data,
	output reg tx_valid,
	input wire tx_ready,
	input wire ref_valid,
	input wire [31:0] position_setpoint,
	input wire [31:0] actual_motor_position,
	input wire [7:0] status_number,
	input wire fatal_present,
	output reg polled_mode,
	output reg [7:0] cmd_letter,
	output reg cmd_strobe
);
	localparam ST_BANNER = 3'h0;
	localparam ST_IDLE = 3'h1;
	localparam ST_RECV = 3'h2;
	localparam ST_SEND = 3'h3;
	localparam ST_NEXT = 3'h4;
	localparam [7:0] VER_HI = `PSC_VER_HI;
	localparam [7:0] VER_LO = `PSC_VER_LO;

	reg [2:0] state_q;
	reg [7:0] buf_q [0:15];
	reg [3:0] len_q;
	reg [3:0] rd_q;
	reg [3:0] ln_q;
	reg [5:0] col_q;
	reg [4:0] si_q;
	reg si_all_q;
	reg [3:0] tok_end;
	reg tok_ok;
	reg tok_query;
	reg [3:0] tok_line;
	reg [4:0] tok_si;
	reg [7:0] ch;
	reg [5:0] line_len;
	wire [7:0] pos_ch;
	wire [7:0] stat_ch;
	wire [7:0] sp_ch;
	wire [7:0] ai_ch;
	integer k;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function is_sep;
		input [7:0] c;
		begin
			is_sep = (c == `PSC_CH_SP) || (c == `PSC_CH_COMMA) || (c == `PSC_CH_TAB);
		end
	endfunction

	function [7:0] dig;
		input [4:0] v;
		input hi;
		begin
			if (hi)
				dig = `PSC_CH_ZERO + {7'h00, v >= 5'h0a};
			else
				dig = `PSC_CH_ZERO + ((v >= 5'h0a) ? {3'h0, v - 5'h0a} : {3'h0, v});
		end
	endfunction

	// ----------------------------------------
	// field characters
	// ----------------------------------------
	// right aligned value, blanked without reference
	psc_dec_digit u_pos (
		.value(actual_motor_position),
		.width(`PSC_POS_DIGITS),
		.col(col_q[3:0] - 4'h2),
		.blank_all(!ref_valid),
		.ch(pos_ch)
	);
	// status number padded to three places
	psc_dec_digit u_stat (
		.value({24'h000000, status_number}),
		.width(`PSC_STAT_DIGITS),
		.col(col_q[3:0] - 4'h2),
		.blank_all(1'b0),
		.ch(stat_ch)
	);
	psc_dec_digit u_sp (
		.value(position_setpoint),
		.width(`PSC_POS_DIGITS),
		.col(col_q[3:0] - 4'h6),
		.blank_all(1'b0),
		.ch(sp_ch)
	);
	psc_dec_digit u_ai (
		.value(actual_motor_position),
		.width(`PSC_POS_DIGITS),
		.col(col_q[3:0] - 4'h8),
		.blank_all(1'b0),
		.ch(ai_ch)
	);

	// ----------------------------------------
	// instruction decode at read pointer
	// ----------------------------------------
	// only syntax is judged here, motion is not waited for
	always @* begin
		tok_end = rd_q + 4'h1;
		tok_ok = 1'b0;
		tok_query = 1'b0;
		tok_line = `PSC_LN_NONE;
		tok_si = 5'h00;
		case (buf_q[rd_q])
		`PSC_CH_P: begin
			tok_ok = 1'b1;
			tok_query = 1'b1;
			tok_line = `PSC_LN_POS;
		end
		`PSC_CH_E: tok_ok = 1'b1;
		`PSC_CH_S: begin
			tok_ok = 1'b1;
			tok_query = 1'b1;
			tok_line = `PSC_LN_STAT;
			if (buf_q[rd_q + 4'h1] == `PSC_CH_I) begin
				tok_end = rd_q + 4'h3;
				if (buf_q[rd_q + 4'h2] == `PSC_CH_EQ)
					tok_end = rd_q + 4'h4;
				tok_si = buf_q[tok_end - 4'h1][4:0] - 5'h10;
				tok_line = (tok_si == 5'h00) ? `PSC_LN_SIX : `PSC_LN_SI5;
				tok_ok = (tok_si <= `PSC_SI_LAST);
			end
		end
		`PSC_CH_F: begin
			tok_ok = 1'b1;
			if (buf_q[rd_q + 4'h1] == `PSC_CH_S) begin
				tok_end = rd_q + 4'h2;
				tok_query = 1'b1;
				tok_line = `PSC_LN_FATAL;
			end
		end
		`PSC_CH_M, `PSC_CH_X: tok_ok = 1'b1;
		default: tok_ok = 1'b0;
		endcase
		// skip operand characters of action instructions
		if (tok_ok && !tok_query) begin
			for (k = 1; k < 16; k = k + 1) begin
				if (tok_end == rd_q + k[3:0] && tok_end < len_q &&
						!is_sep(buf_q[tok_end]) && buf_q[tok_end] > `PSC_CH_EQ)
					tok_end = tok_end;
				else if (tok_end == rd_q + k[3:0] && tok_end < len_q &&
						!is_sep(buf_q[tok_end]))
					tok_end = tok_end + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// reply character generator
	// ----------------------------------------
	// fixed length lines closed by cr then lf
	always @* begin
		case (ln_q)
		`PSC_LN_POS: line_len = `PSC_LEN_POS;
		`PSC_LN_STAT: line_len = `PSC_LEN_STAT;
		`PSC_LN_SI5, `PSC_LN_SIX: line_len = `PSC_LEN_SI;
		`PSC_LN_BANNER: line_len = `PSC_LEN_BANNER;
		`PSC_LN_FATAL: line_len = `PSC_LEN_FATAL;
		default: line_len = `PSC_LEN_ACK;
		endcase
		ch = `PSC_CH_SP;
		if (col_q == line_len)
			ch = `PSC_CH_CR;
		else if (col_q > line_len)
			ch = `PSC_CH_LF;
		else begin
			case (ln_q)
			`PSC_LN_ACK: ch = `PSC_CH_A;
			`PSC_LN_NAK: ch = `PSC_CH_N;
			`PSC_LN_POS: begin
				if (col_q == 6'h00)
					ch = `PSC_CH_LT;
				else if (col_q == 6'h01)
					ch = `PSC_CH_X;
				else if (col_q == `PSC_LEN_POS - 6'h01)
					ch = `PSC_CH_GT;
				else
					ch = pos_ch;
			end
			`PSC_LN_STAT: begin
				if (col_q == 6'h00)
					ch = `PSC_CH_LP;
				else if (col_q == 6'h01)
					ch = `PSC_CH_E;
				else if (col_q == `PSC_LEN_STAT - 6'h01)
					ch = `PSC_CH_RP;
				else
					ch = stat_ch;
			end
			`PSC_LN_BANNER: begin
				case (col_q)
				6'h00: ch = `PSC_CH_V;
				6'h08: ch = `PSC_CH_ZERO + {4'h0, VER_HI[7:4]};
				6'h09: ch = `PSC_CH_ZERO + {4'h0, VER_HI[3:0]};
				6'h0a: ch = `PSC_CH_DOT;
				6'h0b: ch = `PSC_CH_ZERO + {4'h0, VER_LO[7:4]};
				6'h0c: ch = `PSC_CH_ZERO + {4'h0, VER_LO[3:0]};
				default: ch = `PSC_CH_SP;
				endcase
			end
			`PSC_LN_FATAL: begin
				if (col_q < 6'h02)
					ch = `PSC_CH_F + 8'h20;
				else
					ch = `PSC_CH_SP;
			end
			default: begin
				if (col_q == 6'h00)
					ch = dig(si_q, 1'b1);
				else if (col_q == 6'h01)
					ch = dig(si_q, 1'b0);
				else if (si_q == `PSC_SI_POS_LINE) begin
					if (col_q == 6'h03)
						ch = `PSC_CH_X;
					else if (col_q == 6'h04)
						ch = `PSC_CH_W;
					else if (col_q >= 6'h06 && col_q < 6'h0e)
						ch = sp_ch;
					else if (col_q == 6'h13)
						ch = `PSC_CH_X;
					else if (col_q == 6'h14)
						ch = `PSC_CH_I;
					else if (col_q >= 6'h18)
						ch = ai_ch;
				end
			end
			endcase
		end
	end

	// ----------------------------------------
	// record receive and reply sequencer
	// ----------------------------------------
	always @(posedge clock) begin
		if (!rst_n) begin
			state_q <= ST_BANNER;
			len_q <= 4'h0;
			rd_q <= 4'h0;
			ln_q <= `PSC_LN_BANNER;
			col_q <= 6'h00;
			si_q <= 5'h00;
			si_all_q <= 1'b0;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			polled_mode <= 1'b0;
			cmd_letter <= 8'h00;
			cmd_strobe <= 1'b0;
		end else begin
			cmd_strobe <= 1'b0;
			// a fresh colon after the banner restarts reception and drops replies
			if (rx_valid && rx_data == `PSC_CH_COLON && state_q != ST_BANNER) begin
				state_q <= ST_RECV;
				len_q <= 4'h0;
				tx_valid <= 1'b0;
			end else begin
				case (state_q)
				ST_BANNER, ST_SEND: begin
					if (!tx_valid || tx_ready) begin
						tx_data <= ch;
						tx_valid <= 1'b1;
						col_q <= col_q + 6'h01;
						// end only once the lf itself has been taken
						if (col_q > line_len + 6'h01) begin
							tx_valid <= 1'b0;
							col_q <= 6'h00;
							state_q <= (state_q == ST_BANNER) ? ST_IDLE : ST_NEXT;
						end
					end
				end
				ST_RECV: begin
					if (rx_valid && rx_data == `PSC_CH_CR) begin
						state_q <= ST_NEXT;
						rd_q <= 4'h0;
						ln_q <= `PSC_LN_NONE;
					end else if (rx_valid && len_q != `PSC_CMD_MAX) begin
						buf_q[len_q] <= rx_data;
						len_q <= len_q + 4'h1;
					end
				end
				ST_NEXT: begin
					col_q <= 6'h00;
					if (ln_q == `PSC_LN_ACK && tok_query) begin
						ln_q <= tok_line;
						si_q <= (tok_si == 5'h00) ? 5'h01 : tok_si;
						si_all_q <= (tok_line == `PSC_LN_SIX);
						state_q <= ST_SEND;
						rd_q <= tok_end;
					end else if ((ln_q == `PSC_LN_SIX || ln_q == `PSC_LN_SI5) &&
							si_all_q && si_q != `PSC_SI_LAST) begin
						si_q <= si_q + 5'h01;
						state_q <= ST_SEND;
					end else begin
						if (ln_q == `PSC_LN_ACK || ln_q == `PSC_LN_NAK)
							rd_q <= tok_end;
						ln_q <= `PSC_LN_NONE;
						if (rd_q >= len_q)
							state_q <= ST_IDLE;
						else if (is_sep(buf_q[rd_q]))
							rd_q <= rd_q + 4'h1;
						else if (ln_q == `PSC_LN_NONE) begin
							if (buf_q[rd_q] == `PSC_CH_M && buf_q[rd_q + 4'h1] == `PSC_CH_TWO &&
									buf_q[rd_q + 4'h2] == `PSC_CH_TWO)
								polled_mode <= 1'b1;
							cmd_letter <= buf_q[rd_q];
							cmd_strobe <= tok_ok;
							// reply in polled mode or to an M instruction, per instruction
							if (polled_mode || buf_q[rd_q] == `PSC_CH_M) begin
								ln_q <= tok_ok ? `PSC_LN_ACK : `PSC_LN_NAK;
								state_q <= ST_SEND;
							end else
								rd_q <= tok_end;
						end
					end
				end
				default: begin
					if (rx_valid && rx_data == `PSC_CH_COLON)
						state_q <= ST_RECV;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/psc_cmd_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module psc_cmd_monitor (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic polled_mode,
	input wire logic [7:0] cmd_letter,
	input wire logic cmd_strobe
);
	// a reply byte handed over to the host
	wire logic take = tx_valid && tx_ready;
	// a colon from the host may withdraw a waiting reply byte
	property p_tx_hold;
		@(posedge clock) disable iff (!rst_n)
		tx_valid && !tx_ready && !(rx_valid && rx_data == `PSC_CH_COLON)
		|=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped early");
	property p_lf_after_cr;
		@(posedge clock) disable iff (!rst_n)
		take && tx_data == `PSC_CH_CR |=> !tx_valid || tx_data == `PSC_CH_LF;
	endproperty
	a_lf_after_cr: assert property (p_lf_after_cr) else $error("cr not followed by lf");
	property p_ascii;
		@(posedge clock) disable iff (!rst_n) tx_valid |-> !tx_data[7];
	endproperty
	a_ascii: assert property (p_ascii) else $error("reply byte not ascii");
	property p_ack_first;
		@(posedge clock) disable iff (!rst_n) rx_valid && rx_data == `PSC_CH_CR && polled_mode
		&& !tx_valid |-> ##[1:4] tx_valid && (tx_data == `PSC_CH_A || tx_data == `PSC_CH_N);
	endproperty
	a_ack_first: assert property (p_ack_first) else $error("record not acknowledged");
	property p_polled_rise;
		@(posedge clock) disable iff (!rst_n) $rose(polled_mode) |-> cmd_letter == `PSC_CH_M;
	endproperty
	a_polled_rise: assert property (p_polled_rise) else $error("polled mode without select");
	// only recognised instruction letters may be handed on
	property p_strobe_refused;
		@(posedge clock) disable iff (!rst_n) cmd_strobe |-> cmd_letter == `PSC_CH_P ||
		cmd_letter == `PSC_CH_E || cmd_letter == `PSC_CH_S || cmd_letter == `PSC_CH_F ||
		cmd_letter == `PSC_CH_M || cmd_letter == `PSC_CH_X;
	endproperty
	a_strobe_refused: assert property (p_strobe_refused) else $error("strobe for unknown command");
	// no disable here: the reset itself is what is checked
	property p_reset_quiet;
		@(posedge clock) !rst_n |=> !tx_valid && !polled_mode && !cmd_strobe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");
	property p_pos_frame;
		@(posedge clock) disable iff (!rst_n)
		take && tx_data == `PSC_CH_LT |-> ##[1:6] take && tx_data == `PSC_CH_X;
	endproperty
	a_pos_frame: assert property (p_pos_frame) else $error("position line malformed");
	property p_stat_frame;
		@(posedge clock) disable iff (!rst_n)
		take && tx_data == `PSC_CH_LP |-> ##[1:6] take && tx_data == `PSC_CH_E;
	endproperty
	a_stat_frame: assert property (p_stat_frame) else $error("status line malformed");
	c_polled: cover property (@(posedge clock) $rose(polled_mode));
	c_stall: cover property (@(posedge clock) tx_valid && !tx_ready);
	c_pos: cover property (@(posedge clock) take && tx_data == `PSC_CH_LT);
endmodule
bind psc_polled_cmd psc_cmd_monitor psc_cmd_monitor_i (.clock, .rst_n, .rx_data, .rx_valid,
	.tx_data, .tx_valid, .tx_ready, .polled_mode, .cmd_letter, .cmd_strobe);
`default_nettype wire

// *** tb/psc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host end of the serial link
// ----------------------------------------
module psc_host_model (
	input wire logic clock,
	input wire logic slow,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic [7:0] got[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// collect replies; slow mode stalls every other cycle
	always @(posedge clock) begin
		if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	// progress is only learnt by polling
	task automatic send(input string s);
		string r;
		r = {":", s, "\015"};
		for (int i = 0; i < r.len(); i++) begin
			@(posedge clock);
			rx_data <= r[i];
			rx_valid <= 1'b1;
			@(posedge clock);
			rx_valid <= 1'b0;
			rx_data <= ~r[i]; // stale byte never lingers
		end
	endtask
endmodule
`default_nettype wire

// *** tb/psc_polled_cmd_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// polled command bench
// ----------------------------------------
module psc_polled_cmd_bench;
	typedef struct {string cmd; logic rv; logic [31:0] pos; logic [7:0] st; string exp;} psc_row_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ref_valid = 1'b0;
	logic [31:0] pos = 32'h0;
	logic [7:0] stat = 8'h00;
	logic slow = 1'b0;
	wire logic [7:0] rx_data;
	wire logic rx_valid;
	wire logic [7:0] tx_data;
	wire logic tx_valid;
	wire logic tx_ready;
	wire logic polled_mode;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	string nl = "\015\012";
	string q13 = "?????????????";
	string q30 = "??????????????????????????????";
	psc_row_t rows[12];
	psc_polled_cmd psc_polled_cmd_i (.clock, .rst_n, .rx_data, .rx_valid, .tx_data, .tx_valid,
		.tx_ready, .ref_valid, .position_setpoint(pos), .actual_motor_position(pos),
		.status_number(stat), .fatal_present(1'b0), .polled_mode, .cmd_letter(), .cmd_strobe());
	psc_host_model psc_host_model_i (.clock, .slow, .rx_data, .rx_valid, .tx_data, .tx_valid,
		.tx_ready);
	always #50 clock = ~clock;
	// a hang counts as a mismatch
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string what, input logic seen, input logic exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", what, exp, seen);
		end
	endtask
	// send a record, wait for the reply, then a quiet spell
	task automatic run(input string cmd, input string exp);
		int bad;
		bad = -1;
		if (cmd != "") begin
			psc_host_model_i.got.delete();
			psc_host_model_i.send(cmd);
		end
		for (int k = 0; k < 4000 && psc_host_model_i.got.size() < exp.len(); k++)
			@(posedge clock);
		repeat (40) @(posedge clock);
		checks++;
		if (psc_host_model_i.got.size() != exp.len()) begin
			err_total++;
			$display("[FAIL] reply to :%s length expected %0d seen %0d", cmd, exp.len(),
				psc_host_model_i.got.size());
		end else begin
			foreach (psc_host_model_i.got[i])
				if (bad < 0 && exp[i] != "?" && psc_host_model_i.got[i] !== exp[i]) bad = i;
			if (bad >= 0) begin
				err_total++;
				$display("[FAIL] reply to :%s byte %0d expected %h seen %h", cmd, bad, exp[bad],
					psc_host_model_i.got[bad]);
			end
		end
		$display("test :%s done", cmd);
	endtask
	initial begin
		string si0;
		string si5;
		string ff;
		si0 = {"A", nl};
		for (int n = 1; n <= 16; n++) si0 = {si0, $sformatf("%02d", n), q30, nl};
		// setpoint and actual position both 10000 in their fixed columns
		si5 = {"05 XW ", "   10000", "     XI", "      10000"};
		ff = "ff";
		for (int n = 0; n < 20; n++) ff = {ff, " "};
		rows = '{
			'{"M22", 1'b0, 32'h0, 8'h00, {"A", nl}},
			'{"Y", 1'b0, 32'h0, 8'h00, {"N", nl}},
			'{"P", 1'b0, 32'h0, 8'h00, {"A", nl, "<X        >", nl}},
			'{"P", 1'b1, 32'h4d2, 8'h00, {"A", nl, "<X    1234>", nl}},
			'{"P", 1'b1, 32'h2710, 8'h00, {"A", nl, "<X   10000>", nl}},
			'{"S", 1'b0, 32'h0, 8'h06, {"A", nl, "(E  6)", nl}},
			'{"S", 1'b0, 32'h0, 8'h4a, {"A", nl, "(E 74)", nl}},
			'{"S", 1'b0, 32'h0, 8'h67, {"A", nl, "(E103)", nl}},
			'{"SI5", 1'b1, 32'h2710, 8'h00, {"A", nl, si5, nl}},
			'{"P S", 1'b1, 32'h4d2, 8'h06, {"A", nl, "<X    1234>", nl, "A", nl, "(E  6)", nl}},
			'{"FS", 1'b0, 32'h0, 8'h00, {"A", nl, ff, nl}},
			'{"X=100 E", 1'b0, 32'h0, 8'h00, {"A", nl, "A", nl}}};
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		run("", {q13, nl});
		foreach (rows[i]) begin
			ref_valid <= rows[i].rv;
			pos <= rows[i].pos;
			stat <= rows[i].st;
			@(posedge clock);
			run(rows[i].cmd, rows[i].exp);
		end
		chk("polled_mode", polled_mode, 1'b1);
		// new colon throws the partial record away
		stat <= 8'h06;
		run("Y:S", {"A", nl, "(E  6)", nl});
		// every info line while the host stalls
		slow <= 1'b1;
		run("SI0", si0);
		slow <= 1'b0;
		// reset mid run: banner again, polled mode dropped
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		chk("polled_mode", polled_mode, 1'b0);
		psc_host_model_i.got.delete();
		rst_n <= 1'b1;
		run("", {q13, nl});
		run("S", "");
		tally_and_finish();
	end
endmodule
`default_nettype wire
